/* File: shared/cdisk_pkg.sv */
// Shared constants and types for the cartridge disk command block
package cdisk_pkg;

  // Data path widths
  localparam int unsigned WORD_W = 16;
  localparam int unsigned MEMA_W = 32;

  // Switch default byte base and the same base seen as a bus word address
  localparam logic [15:0] BASE_BYTE_DEF = 16'hF800;
  localparam logic [19:0] BUS_WORD_DEF  = 20'hFFC00;

  // Byte address split: block select above, word index, even-byte bit
  localparam int unsigned BLK_LSB  = 4;
  localparam int unsigned IDX_MSB  = 3;
  localparam int unsigned IDX_LSB  = 1;
  localparam int unsigned BYTE_BIT = 0;

  // Word index of each setup/status word
  localparam logic [2:0] IDX_STATUS  = 3'h0;
  localparam logic [2:0] IDX_CMD     = 3'h1;
  localparam logic [2:0] IDX_CYL     = 3'h2;
  localparam logic [2:0] IDX_HDSEC   = 3'h3;
  localparam logic [2:0] IDX_COUNT   = 3'h4;
  localparam logic [2:0] IDX_ADDR_HI = 3'h5;
  localparam logic [2:0] IDX_ADDR_LO = 3'h6;
  localparam logic [2:0] IDX_LAUNCH  = 3'h7;

  // Fields of the command word and the head/sector word
  localparam int unsigned CMD_MSB  = 7;
  localparam int unsigned CMD_LSB  = 5;
  localparam int unsigned UNIT_MSB = 1;
  localparam int unsigned UNIT_LSB = 0;
  localparam int unsigned HEAD_MSB = 15;
  localparam int unsigned HEAD_LSB = 8;
  localparam int unsigned SEC_MSB  = 7;
  localparam int unsigned SEC_LSB  = 0;

  // Status word bits
  localparam int unsigned ST_DONE   = 15;
  localparam int unsigned ST_ERR    = 14;
  localparam int unsigned ST_BUSY   = 13;
  localparam int unsigned ST_WPROT  = 3;
  localparam int unsigned ST_FAULT  = 2;
  localparam int unsigned ST_NOTRDY = 1;
  localparam int unsigned ST_ABORT  = 0;

  // Small constants
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONE  = 16'h0001;
  localparam logic [31:0] ADDR_ONE  = 32'h0000_0001;

  typedef enum logic [2:0] {
    CMD_STORE = 3'b000,
    CMD_FMT   = 3'b001,
    CMD_RD    = 3'b010,
    CMD_WR    = 3'b011,
    CMD_RDU   = 3'b100,
    CMD_WRU   = 3'b101,
    CMD_SEEK  = 3'b110,
    CMD_REST  = 3'b111
  } cmd_e;

endpackage

/* File: hw/carriage_ctrl.sv */
// Head carriage restore sequencer, spindle stop mode and fault latch
`timescale 1ns/1ps
module carriage_ctrl (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic runMode,
  input  wire logic restoreReq,
  input  wire logic panelReset,
  input  wire logic driveFault,
  input  wire logic atFwdEnd,
  input  wire logic atTrack0,
  output logic      carriageFwd,
  output logic      carriageRev,
  output logic      carriageRetract,
  output logic      spindleOn,
  output logic      faultLatched,
  output logic      restoreDone
);
  import cdisk_pkg::*;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_FWD  = 2'b01,
    C_REV  = 2'b10
  } car_state_e;

  typedef struct packed {
    car_state_e state;
    logic       fwd;
    logic       rev;
    logic       retract;
    logic       spin;
    logic       fault;
    logic       done;
  } car_s;

  car_s q;
  car_s d;

  // Stop mode, fault latch and the forward-then-back restore walk
  always_comb begin
    d         = q;
    d.done    = 1'b0;
    d.spin    = runMode;
    d.retract = !runMode;
    if (restoreReq || panelReset) begin
      d.fault = 1'b0;
    end
    if (driveFault) begin
      d.fault = 1'b1;                        // Set wins over a same-cycle clear
    end
    unique case (q.state)
      C_IDLE: begin
        if ((restoreReq || panelReset) && runMode) begin
          d.state = C_FWD;
        end else if (restoreReq) begin
          d.done = 1'b1;                     // Nothing to move while stopped
        end
      end
      C_FWD: begin
        if (!runMode) begin
          d.state = C_IDLE;
          d.done  = 1'b1;
        end else if (atFwdEnd) begin
          d.state = C_REV;
        end
      end
      C_REV: begin
        if (!runMode || atTrack0) begin
          d.state = C_IDLE;
          d.done  = 1'b1;
        end
      end
      default: d.state = C_IDLE;
    endcase
    // Drive lines registered so the carriage never sees a glitch
    d.fwd = (d.state == C_FWD);
    d.rev = (d.state == C_REV);
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign carriageFwd     = q.fwd;
  assign carriageRev     = q.rev;
  assign carriageRetract = q.retract;
  assign spindleOn       = q.spin;
  assign faultLatched    = q.fault;
  assign restoreDone     = q.done;

endmodule // carriage_ctrl

/* File: hw/word_mover.sv */
// Word-at-a-time mover between the disk stream and host memory
`timescale 1ns/1ps
module word_mover (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        readDir,
  input  wire logic        wrInhibit,
  input  wire logic        abort,
  input  wire logic [15:0] count,
  input  wire logic [31:0] addr,
  input  wire logic [15:0] diskRdData,
  input  wire logic        diskRdValid,
  input  wire logic        memAck,
  input  wire logic [15:0] memRdData,
  output logic             memReq,
  output logic             memWrite,
  output logic [31:0]      memAddr,
  output logic [15:0]      memWrData,
  output logic [15:0]      diskWrData,
  output logic             diskWrStrobe,
  output logic             step,
  output logic             done
);
  import cdisk_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE    = 3'b000,
    M_DISKIN  = 3'b001,
    M_MEMOUT  = 3'b010,
    M_MEMIN   = 3'b011,
    M_DISKOUT = 3'b100
  } mov_state_e;

  typedef struct packed {
    mov_state_e  state;
    logic        dir;
    logic [15:0] left;
    logic [31:0] addr;
    logic [15:0] data;
    logic        memReq;
    logic        memWrite;
    logic        strobe;
    logic        step;
    logic        done;
  } mov_s;

  mov_s q;
  mov_s d;

  // One word per pass; the next word waits for the previous handshake
  always_comb begin
    d        = q;
    d.step   = 1'b0;
    d.done   = 1'b0;
    d.strobe = 1'b0;
    if (abort) begin
      d.state  = M_IDLE;
      d.memReq = 1'b0;
    end else begin
      unique case (q.state)
        M_IDLE: begin
          if (start) begin
            d.left = count;
            d.addr = addr;
            d.dir  = readDir;
            if (count == WORD_ZERO) begin
              d.done = 1'b1;
            end else if (readDir) begin
              d.state = M_DISKIN;
            end else begin
              d.state    = M_MEMIN;
              d.memReq   = 1'b1;
              d.memWrite = 1'b0;
            end
          end
        end
        M_DISKIN: begin
          if (diskRdValid) begin
            d.data     = diskRdData;
            d.memReq   = 1'b1;
            d.memWrite = 1'b1;
            d.state    = M_MEMOUT;
          end
        end
        M_MEMIN: begin
          if (memAck) begin
            d.memReq = 1'b0;
            d.data   = memRdData;
            d.state  = M_DISKOUT;
          end
        end
        M_MEMOUT, M_DISKOUT: begin
          // A locked disk never sees a strobe, even mid-transfer
          d.strobe = (q.state == M_DISKOUT) && !wrInhibit;
          if (q.state == M_DISKOUT || memAck) begin
            d.memReq = 1'b0;
            d.step   = 1'b1;
            d.left   = q.left - WORD_ONE;
            d.addr   = q.addr + ADDR_ONE;
            if (q.left == WORD_ONE) begin
              d.state = M_IDLE;
              d.done  = 1'b1;
            end else if (q.dir) begin
              d.state = M_DISKIN;
            end else begin
              d.state    = M_MEMIN;
              d.memReq   = 1'b1;
              d.memWrite = 1'b0;
            end
          end
        end
        default: d.state = M_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign memReq       = q.memReq;
  assign memWrite     = q.memWrite;
  assign memAddr      = q.addr;
  assign memWrData    = q.data;
  assign diskWrData   = q.data;
  assign diskWrStrobe = q.strobe;
  assign step         = q.step;
  assign done         = q.done;

endmodule // word_mover

/* File: hw/cartridge_disk_command_block.sv */
// Setup/status word file and command interpreter of the cartridge disk controller
`timescale 1ns/1ps
module cartridge_disk_command_block #(
  parameter logic [15:0] WORDS_PER_TRACK = 16'h0F00,
  parameter logic [15:0] SECT_PER_TRACK  = 16'h0014,
  parameter logic [15:0] OVERHEAD_WORDS  = 16'h000E,
  parameter logic [15:0] TRACKS_PER_CYL  = 16'h0002,
  parameter logic [15:0] CYLS_PER_UNIT   = 16'h0198
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic [15:0]                  baseAddr,
  input  wire logic [15:0]                  regAddr,
  input  wire logic [cdisk_pkg::WORD_W-1:0] regWrData,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  output logic      [cdisk_pkg::WORD_W-1:0] regRdData,
  input  wire logic                         startStop,
  input  wire logic                         faultResetPress,
  input  wire logic                         fixedWriteLock,
  input  wire logic                         removable_write_lock,
  input  wire logic                         driveReady,
  input  wire logic                         driveFault,
  input  wire logic                         atFwdEnd,
  input  wire logic                         atTrack0,
  output logic                              carriageFwd,
  output logic                              carriageRev,
  output logic                              carriageRetract,
  output logic                              spindleOn,
  output logic                              faultLamp,
  output logic                              diskGate,
  output logic      [2:0]                   diskOp,
  output logic      [1:0]                   diskUnit,
  output logic      [15:0]                  diskCyl,
  output logic      [7:0]                   diskHead,
  output logic      [7:0]                   diskSector,
  input  wire logic [cdisk_pkg::WORD_W-1:0] diskRdData,
  input  wire logic                         diskRdValid,
  output logic      [cdisk_pkg::WORD_W-1:0] diskWrData,
  output logic                              diskWrStrobe,
  output logic                              memReq,
  output logic                              memWrite,
  output logic      [cdisk_pkg::MEMA_W-1:0] memAddr,
  output logic      [cdisk_pkg::WORD_W-1:0] memWrData,
  input  wire logic                         memAck,
  input  wire logic [cdisk_pkg::WORD_W-1:0] memRdData
);
  import cdisk_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_START   = 3'b001,
    S_XFER    = 3'b010,
    S_RESTORE = 3'b011,
    S_DONE    = 3'b100
  } top_state_e;

  typedef struct packed {
    top_state_e       state;
    logic [7:0][15:0] words;
    logic [15:0]      rdData;
    cmd_e             op;
    logic [3:0]       errs;
    logic             gate;
    logic             restoreReq;
    logic             moverStart;
  } top_s;

  top_s q;
  top_s d;

  logic        hit;
  logic [2:0]  idx;
  logic        notReady;
  logic        writeOp;
  logic        lockSel;
  logic        faultLatched;
  logic        restoreDone;
  logic        moverStep;
  logic        moverDone;
  logic        moverAbort;
  logic [31:0] bufAddr;

  // Block decode: base assumed aligned to the eight-word block
  assign hit = (regAddr[15:BLK_LSB] == baseAddr[15:BLK_LSB])
               && !regAddr[BYTE_BIT];
  assign idx = regAddr[IDX_MSB:IDX_LSB];

  // Conditions checked when a command is launched
  assign notReady = !startStop || !driveReady;
  assign writeOp  = (q.op == CMD_FMT) || (q.op == CMD_WR) || (q.op == CMD_WRU);
  // Even units are the fixed disk, odd units the cartridge
  assign lockSel  = q.words[IDX_CMD][UNIT_LSB] ? removable_write_lock
                                               : fixedWriteLock;
  assign bufAddr  = {q.words[IDX_ADDR_HI], q.words[IDX_ADDR_LO]};
  assign moverAbort = driveFault && (q.state == S_XFER);

  // Word file, launch decode and command sequencing
  always_comb begin
    d            = q;
    d.restoreReq = 1'b0;
    d.moverStart = 1'b0;
    d.rdData     = WORD_ZERO;
    if (regRd && hit) begin
      d.rdData = q.words[idx];
    end
    unique case (q.state)
      S_IDLE: begin
        if (regWr && hit) begin
          d.words[idx] = regWrData;
          if (idx == IDX_LAUNCH) begin
            d.state = S_START;
            d.op    = cmd_e'(q.words[IDX_CMD][CMD_MSB:CMD_LSB]);
            d.errs  = 4'h0;
            d.words[IDX_STATUS][ST_BUSY] = 1'b1;
            d.words[IDX_STATUS][ST_DONE] = 1'b0;
          end
        end
      end
      S_START: begin
        d.state = S_DONE;
        if (notReady && (q.op != CMD_STORE) && (q.op != CMD_SEEK)) begin
          d.errs[ST_NOTRDY] = 1'b1;
        end else if (faultLatched && (q.op != CMD_REST)) begin
          d.errs[ST_FAULT] = 1'b1;
        end else if (writeOp && lockSel) begin
          d.errs[ST_WPROT] = 1'b1;
        end else begin
          unique case (q.op)
            CMD_STORE: begin
              d.words[IDX_CYL]     = WORDS_PER_TRACK;
              d.words[IDX_HDSEC]   = SECT_PER_TRACK;
              d.words[IDX_COUNT]   = OVERHEAD_WORDS;
              d.words[IDX_ADDR_HI] = TRACKS_PER_CYL;
              d.words[IDX_ADDR_LO] = CYLS_PER_UNIT;
            end
            CMD_SEEK: begin
              d.state = S_DONE;
            end
            CMD_REST: begin
              d.restoreReq = 1'b1;
              d.state      = S_RESTORE;
            end
            CMD_FMT, CMD_RD, CMD_WR, CMD_RDU, CMD_WRU: begin
              // Format uses the write path for the word count held in the count word
              d.moverStart = 1'b1;
              d.gate       = 1'b1;
              d.state      = S_XFER;
            end
          endcase
        end
      end
      S_XFER: begin
        if (moverStep) begin
          // Count and buffer pointer follow the transfer word by word
          d.words[IDX_COUNT] = q.words[IDX_COUNT] - WORD_ONE;
          {d.words[IDX_ADDR_HI], d.words[IDX_ADDR_LO]} = bufAddr + ADDR_ONE;
        end
        if (moverAbort) begin
          d.errs[ST_ABORT] = 1'b1;
          d.errs[ST_FAULT] = 1'b1;
          d.gate           = 1'b0;
          d.state          = S_DONE;
        end else if (moverDone) begin
          d.gate  = 1'b0;
          d.state = S_DONE;
        end
      end
      S_RESTORE: begin
        if (restoreDone) begin
          d.state = S_DONE;
        end
      end
      S_DONE: begin
        // Status left behind for the host to judge the outcome
        d.words[IDX_STATUS]            = WORD_ZERO;
        d.words[IDX_STATUS][ST_DONE]   = 1'b1;
        d.words[IDX_STATUS][ST_ERR]    = |q.errs;
        d.words[IDX_STATUS][ST_WPROT]  = q.errs[ST_WPROT];
        d.words[IDX_STATUS][ST_FAULT]  = q.errs[ST_FAULT];
        d.words[IDX_STATUS][ST_NOTRDY] = q.errs[ST_NOTRDY];
        d.words[IDX_STATUS][ST_ABORT]  = q.errs[ST_ABORT];
        d.state                        = S_IDLE;
      end
      default: d.state = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Restore walk, stop mode and fault latch; panel reset restores too
  carriage_ctrl u_carriage (
    .clk_sys         (clk_sys),
    .rst_n           (rst_n),
    .runMode         (startStop),
    .restoreReq      (q.restoreReq),
    .panelReset      (faultResetPress),
    .driveFault      (driveFault),
    .atFwdEnd        (atFwdEnd),
    .atTrack0        (atTrack0),
    .carriageFwd     (carriageFwd),
    .carriageRev     (carriageRev),
    .carriageRetract (carriageRetract),
    .spindleOn       (spindleOn),
    .faultLatched    (faultLatched),
    .restoreDone     (restoreDone)
  );

  // Data transfers; raw versus formatted only changes what the drive does
  word_mover u_mover (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .start        (q.moverStart),
    .readDir      ((q.op == CMD_RD) || (q.op == CMD_RDU)),
    .wrInhibit    (lockSel),
    .abort        (moverAbort),
    .count        (q.words[IDX_COUNT]),
    .addr         (bufAddr),
    .diskRdData   (diskRdData),
    .diskRdValid  (diskRdValid),
    .memAck       (memAck),
    .memRdData    (memRdData),
    .memReq       (memReq),
    .memWrite     (memWrite),
    .memAddr      (memAddr),
    .memWrData    (memWrData),
    .diskWrData   (diskWrData),
    .diskWrStrobe (diskWrStrobe),
    .step         (moverStep),
    .done         (moverDone)
  );

  // Registered outputs taken straight from the state
  assign regRdData  = q.rdData;
  assign faultLamp  = faultLatched;
  assign diskGate   = q.gate;
  assign diskOp     = q.op;
  assign diskUnit   = q.words[IDX_CMD][UNIT_MSB:UNIT_LSB];
  assign diskCyl    = q.words[IDX_CYL];
  assign diskHead   = q.words[IDX_HDSEC][HEAD_MSB:HEAD_LSB];
  assign diskSector = q.words[IDX_HDSEC][SEC_MSB:SEC_LSB];

  // Checks on the command sequencing
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence launchWr;
    (q.state == S_IDLE) && regWr && hit && (idx == IDX_LAUNCH);
  endsequence

  sequence seekOk;
    (q.state == S_START) && (q.op == CMD_SEEK) && !faultLatched;
  endsequence

  launch_start_a: assert property (
    launchWr |=> (q.state == S_START) ##1 (q.state != S_IDLE))
    else $error("launch word write did not start a command");

  early_words_a: assert property (
    (q.state == S_IDLE) && regWr && hit && (idx != IDX_LAUNCH)
    |=> (q.state == S_IDLE) && !diskGate && !q.moverStart)
    else $error("early setup word write started activity");

  cmd_field_a: assert property (
    launchWr |=> (q.op == $past(q.words[IDX_CMD][CMD_MSB:CMD_LSB])))
    else $error("command not taken from bits 5-7");

  store_geom_a: assert property (
    (q.state == S_START) && (q.op == CMD_STORE) && !faultLatched
    |=> (q.words[IDX_CYL] == WORDS_PER_TRACK) && (q.words[IDX_ADDR_LO] == CYLS_PER_UNIT))
    else $error("geometry words not returned");

  seek_normal_a: assert property (
    seekOk |-> ##2 (q.state == S_IDLE) && !q.words[IDX_STATUS][ST_ERR]
    && q.words[IDX_STATUS][ST_DONE] && !carriageFwd)
    else $error("seek did not complete normally");

  wprot_block_a: assert property (
    diskWrStrobe |-> !$past(lockSel))
    else $error("write strobe reached a locked disk");

  xfer_count_a: assert property (
    (q.state == S_XFER) && moverStep
    |=> (q.words[IDX_COUNT] == $past(q.words[IDX_COUNT]) - WORD_ONE))
    else $error("word count not stepped");

  restore_clear_a: assert property (
    q.restoreReq && !driveFault |=> !faultLatched)
    else $error("restore left a fault latched");

  stop_mode_a: assert property (
    !startStop |=> carriageRetract && !spindleOn)
    else $error("stop mode left spindle on or carriage out");

  err_report_a: assert property (
    (q.state == S_START) && writeOp && lockSel && !notReady && !faultLatched
    |-> ##2 q.words[IDX_STATUS][ST_ERR] && q.words[IDX_STATUS][ST_WPROT])
    else $error("write protect error not reported");

endmodule // cartridge_disk_command_block

/* File: testbench/host_mem_model.sv */
// Far-side model: memory responder and head carriage mechanics
`timescale 1ns/1ps
module host_mem_model (
  input  wire logic   clk_sys,
  input  wire logic   memReq,
  input  wire logic   carriageFwd,
  input  wire logic   carriageRev,
  output logic        memAck,
  output logic [15:0] memRdData,
  output logic        atFwdEnd,
  output logic        atTrack0
);
  logic [2:0] pos = 3'h2;
  logic [1:0] dly = 2'h0;
  initial memAck = 1'b0;
  initial memRdData = 16'h0000;
  // Slow answer; data churns outside the ack cycle so stale reads show up
  always @(posedge clk_sys) begin
    memAck <= 1'b0;
    memRdData <= ~memRdData;
    if (memReq && !memAck) begin
      dly <= dly + 2'h1;
      if (dly == 2'h2) begin
        memAck <= 1'b1;
        memRdData <= 16'hC3A5;
        dly <= 2'h0;
      end
    end
  end
  // Carriage travel: five steps from track 0 to the forward stop
  always @(posedge clk_sys) begin
    if (carriageFwd && pos != 3'h5) pos <= pos + 3'h1;
    else if (carriageRev && pos != 3'h0) pos <= pos - 3'h1;
  end
  assign atFwdEnd = (pos == 3'h5);
  assign atTrack0 = (pos == 3'h0);
endmodule // host_mem_model

/* File: testbench/cartridge_disk_command_block_bench.sv */
// Testbench: word file access and command runs of the disk command block
`timescale 1ns/1ps
module cartridge_disk_command_block_bench;
  logic clk_sys = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic startStop = 1'b1, driveReady = 1'b1, driveFault = 1'b0, diskRdValid = 1'b0;
  logic removable_write_lock = 1'b0, fixedWriteLock = 1'b0, faultResetPress = 1'b0;
  logic memAck, memReq, memWrite, atFwdEnd, atTrack0, diskWrStrobe;
  logic [2:0] diskOp;
  logic [31:0] memAddr;
  logic carriageFwd, carriageRev, carriageRetract, spindleOn, faultLamp, diskGate;
  logic [15:0] regAddr = 16'h0000, regWrData = 16'h0000, diskRdData = 16'h0000;
  logic [15:0] regRdData, memRdData, memWrData, diskWrData, v, wrSeen = 16'h0000;
  logic [15:0] geo [2:6] = '{16'h0F00, 16'h0014, 16'h000E, 16'h0002, 16'h0198};
  int num_errors = 0, checks = 0, cyc = 0, nStb = 0;
  always #50 clk_sys = ~clk_sys;
  cartridge_disk_command_block dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .baseAddr(16'hF800), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .startStop(startStop),
    .faultResetPress(faultResetPress),
    .fixedWriteLock(fixedWriteLock), .removable_write_lock(removable_write_lock),
    .driveReady(driveReady), .driveFault(driveFault), .atFwdEnd(atFwdEnd),
    .atTrack0(atTrack0), .carriageFwd(carriageFwd), .carriageRev(carriageRev),
    .carriageRetract(carriageRetract), .spindleOn(spindleOn), .faultLamp(faultLamp),
    .diskGate(diskGate), .diskOp(diskOp), .diskUnit(), .diskCyl(), .diskHead(),
    .diskSector(), .diskRdData(diskRdData), .diskRdValid(diskRdValid),
    .diskWrData(diskWrData), .diskWrStrobe(diskWrStrobe),
    .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memWrData(memWrData),
    .memAck(memAck), .memRdData(memRdData));
  host_mem_model far_u (.clk_sys(clk_sys), .memReq(memReq), .carriageFwd(carriageFwd),
    .carriageRev(carriageRev), .memAck(memAck), .memRdData(memRdData),
    .atFwdEnd(atFwdEnd), .atTrack0(atTrack0));
  // Write strobes last one cycle; latch each one as it passes
  always @(posedge clk_sys) begin
    if (diskWrStrobe) begin
      wrSeen <= diskWrData;
      nStb <= nStb + 1;
    end
  end
  function automatic logic [15:0] adr(input int i);
    return 16'hF800 + 16'(2 * i);
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One-cycle strobes, changed just after the edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rdv(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys) d = regRdData;
    @(posedge clk_sys);
  endtask
  // Launch, then poll the status word under a bound
  task automatic run(input logic [15:0] cmd);
    wr(adr(1), cmd);
    wr(adr(7), 16'h0000);
    for (int i = 0; i < 100; i++) begin
      rdv(adr(0), v);
      if (v[15] === 1'b1) break;
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdv(adr(0), v); chk(v, 16'h0000);
    for (int i = 2; i < 7; i++) wr(adr(i), 16'(16'h1110 * i));
    wr(16'hF810, 16'hFFFF);
    chk({15'h0, diskGate}, 16'h0000);
    for (int i = 2; i < 7; i++) begin
      rdv(adr(i), v); chk(v, 16'(16'h1110 * i));
    end
    rdv(16'hF805, v); chk(v, 16'h0000);
    run(16'h0000); chk(v, 16'h8000);
    for (int i = 2; i < 7; i++) begin
      rdv(adr(i), v); chk(v, geo[i]);
    end
    run(16'h00C0); chk(v, 16'h8000);
    removable_write_lock <= 1'b1;
    wr(adr(4), 16'h0001);
    run(16'h0061); chk(v, 16'hC008);
    removable_write_lock <= 1'b0;
    driveFault <= 1'b1;
    @(posedge clk_sys) driveFault <= 1'b0;
    @(posedge clk_sys) chk({15'h0, faultLamp}, 16'h0001);
    run(16'h00E0); chk(v, 16'h8000);
    chk({14'h0, atTrack0, faultLamp}, 16'h0002);
    wr(adr(4), 16'h0001);
    wr(adr(6), 16'h0100);
    wr(adr(1), 16'h0040);
    wr(adr(7), 16'h0000);
    repeat (4) @(posedge clk_sys);
    diskRdData <= 16'h5A5A;
    diskRdValid <= 1'b1;
    @(posedge clk_sys) diskRdValid <= 1'b0;
    for (int i = 0; i < 20 && memReq !== 1'b1; i++) @(negedge clk_sys);
    chk(memWrData, 16'h5A5A); chk({15'h0, memWrite}, 16'h0001);
    chk(memAddr[15:0], 16'h0100);
    chk({13'h0, diskOp}, 16'h0002);
    run(16'h0040); chk(v[15:14], 2'b10);
    rdv(adr(4), v); chk(v, 16'h0000);
    run(16'h0080); chk(v, 16'h8000);
    wr(adr(4), 16'h0001);
    run(16'h00A0); chk(v, 16'h8000);
    chk(wrSeen, 16'hC3A5); chk(16'(nStb), 16'h0001);
    fixedWriteLock <= 1'b1;
    run(16'h0020); chk(v, 16'hC008);
    fixedWriteLock <= 1'b0;
    driveFault <= 1'b1;
    @(posedge clk_sys) driveFault <= 1'b0;
    faultResetPress <= 1'b1;
    @(posedge clk_sys) faultResetPress <= 1'b0;
    @(negedge clk_sys) chk({14'h0, carriageFwd, faultLamp}, 16'h0002);
    @(posedge clk_sys) startStop <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk({carriageRetract, spindleOn}, 16'h0002);
    run(16'h0040); chk(v, 16'hC002);
    give_verdict;
  end
endmodule // cartridge_disk_command_block_bench
